// ---- inc/ift_consts.vh ----
// constants for the intermittent fault trip timer
`ifndef IFT_CONSTS_VH
`define IFT_CONSTS_VH

// widths
`define IFT_TW            19
`define IFT_SW            16
`define IFT_THR_W         8
`define IFT_LOG_DEPTH     12
`define IFT_LOG_AW        4
`define IFT_REC_W         160

// timing, processing tick of 5 ms
`define IFT_TICK_MS       5
`define IFT_FWD_HOLD_MS   300
`define IFT_REV_HOLD_MS   300
`define IFT_OP_DELAY_MS   500
`define IFT_BLOCK_LEAD_MS 5
`define IFT_FWD_HOLD_TICKS (`IFT_FWD_HOLD_MS / `IFT_TICK_MS)
`define IFT_REV_HOLD_TICKS (`IFT_REV_HOLD_MS / `IFT_TICK_MS)
`define IFT_OP_DELAY_TICKS (`IFT_OP_DELAY_MS / `IFT_TICK_MS)
`define IFT_BLOCK_LEAD_TICKS ((`IFT_BLOCK_LEAD_MS + `IFT_TICK_MS - 1) / `IFT_TICK_MS)

// reset values
`define IFT_SPK_THR_RST   8'h02
`define IFT_EVSEL_RST     10'h3FF
`define IFT_GRP_RST       3'h0

// register byte offsets
`define IFT_REG_CFG       8'h00
`define IFT_REG_FWD_HOLD  8'h04
`define IFT_REG_REV_HOLD  8'h08
`define IFT_REG_OP_DELAY  8'h0C
`define IFT_REG_SPK_THR   8'h10
`define IFT_REG_STATUS    8'h14
`define IFT_REG_INT_STAT  8'h18
`define IFT_REG_INT_MASK  8'h1C
`define IFT_REG_REC_SEL   8'h20
`define IFT_REG_REC_W0    8'h24
`define IFT_REG_REC_W1    8'h28
`define IFT_REG_REC_W2    8'h2C
`define IFT_REG_REC_W3    8'h30
`define IFT_REG_REC_W4    8'h34
`define IFT_REG_COUNTS    8'h38
`define IFT_REG_REMAIN    8'h3C

// field positions
`define IFT_CFG_GRP_LSB   0
`define IFT_CFG_EVSEL_LSB 4
`define IFT_ST_LOGCNT_LSB 8

// event codes, also bit index of the pending vector
`define IFT_EV_FWD_ON     4'h0
`define IFT_EV_FWD_OFF    4'h1
`define IFT_EV_REV_ON     4'h2
`define IFT_EV_REV_OFF    4'h3
`define IFT_EV_TRIP_ON    4'h4
`define IFT_EV_TRIP_OFF   4'h5
`define IFT_EV_BLK_ON     4'h6
`define IFT_EV_BLK_OFF    4'h7
`define IFT_EV_IEF_ON     4'h8
`define IFT_EV_IEF_OFF    4'h9
`define IFT_EV_NORMAL     4'hA
`define IFT_EV_LOCKED     4'hB
`define IFT_EV_LOG_MASK   12'h055

`endif

// ---- logic/ift_log_mem.v ----
// record log memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module ift_log_mem #(
  parameter W     = 160,
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  input  wire         mclk,
  input  wire         we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);
  reg [W-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    // out-of-range index reads zero rather than undefined
    if (raddr < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= {W{1'b0}};
    end
  end
endmodule // ift_log_mem
`default_nettype wire

// ---- logic/ift_trip_timer.v ----
// intermittent earth fault timing, trip decision, events and record log
// Function
// - forward hold timer starts/restarts per forward spike; expiry clears forward start
// - reverse hold timer starts/restarts per reverse spike; expiry clears reverse start
// - operating delay starts when forward hold runs and start is on
// - forward hold expiry releases function and clears operating delay
// - trip only when forward spike count exceeds spike threshold
// - delay elapsed with too few spikes: no trip, release at hold expiry; here later spikes past the threshold still trip before expiry
// - events on status changes, per-event selection of ON and OFF
// - ON/OFF codes for five states plus normal fault and locked codes
// - each event carries time stamp and process data of that moment
// - circular log of last 12 records, written on start/trip/block ON
// - record holds time, code, delay remaining, flags, spikes left, group
// - separate forward and reverse spike counts kept and stored per record
// - blocking sampled each tick; blocked replaces start and drops start
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "ift_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module ift_trip_timer #(
  parameter TW        = `IFT_TW,
  parameter SW        = `IFT_SW,
  parameter LOG_DEPTH = `IFT_LOG_DEPTH,
  parameter LOG_AW    = `IFT_LOG_AW
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        tick,
  input  wire        fwd_spike,
  input  wire        rev_spike,
  input  wire        pickup,
  input  wire        block_in,
  input  wire        normal_fault,
  input  wire [47:0] time_ms,
  input  wire [7:0]  bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [31:0] bus_rdata,
  output wire        forward_start,
  output wire        reverse_start,
  output wire        trip,
  output wire        blocked,
  output reg         evt_valid,
  output reg  [3:0]  evt_code,
  output reg  [47:0] evt_time,
  output reg  [TW-1:0] evt_remain,
  output reg  [SW-1:0] evt_fwd_count,
  output reg  [SW-1:0] evt_rev_count,
  output reg         irq
);
  localparam [TW-1:0] T_ONE    = 1;
  localparam [SW-1:0] S_ONE    = 1;
  localparam [SW-1:0] S_MAX    = {SW{1'b1}};
  localparam [TW-1:0] FWD_RST  = `IFT_FWD_HOLD_TICKS;
  localparam [TW-1:0] REV_RST  = `IFT_REV_HOLD_TICKS;
  localparam [TW-1:0] OP_RST   = `IFT_OP_DELAY_TICKS;
  localparam [LOG_AW-1:0] A_ONE  = 1;
  localparam [LOG_AW-1:0] A_FULL = LOG_DEPTH[LOG_AW-1:0];
  localparam [LOG_AW-1:0] A_LAST = A_FULL - A_ONE;

  // software registers
  reg [TW-1:0]         fwd_hold_reg;
  reg [TW-1:0]         rev_hold_reg;
  reg [TW-1:0]         op_delay_reg;
  reg [`IFT_THR_W-1:0] spk_thr_reg;
  reg [2:0]            grp_reg;
  reg [9:0]            evsel_reg;
  reg [4:0]            int_stat_reg;
  reg [4:0]            int_mask_reg;
  reg [LOG_AW-1:0]     rec_sel_reg;
  // processing state
  reg [TW-1:0]         fwd_tmr_reg;
  reg [TW-1:0]         rev_tmr_reg;
  reg [TW-1:0]         op_cnt_reg;
  reg                  fwd_run_reg;
  reg                  rev_run_reg;
  reg                  op_run_reg;
  reg                  fwd_st_reg;
  reg                  rev_st_reg;
  reg                  trip_reg;
  reg                  blk_reg;
  reg                  lock_reg;
  reg                  lock_d_reg;
  reg                  norm_reg;
  reg [SW-1:0]         fcnt_reg;
  reg [SW-1:0]         rcnt_reg;
  reg [4:0]            st_d_reg;
  reg [11:0]           pend_reg;
  // event snapshot
  reg [47:0]           snap_time_reg;
  reg [TW-1:0]         snap_rem_reg;
  reg [SW-1:0]         snap_f_reg;
  reg [SW-1:0]         snap_r_reg;
  reg [SW-1:0]         snap_left_reg;
  reg                  snap_fst_reg;
  reg                  snap_rst_reg;
  // log
  reg [LOG_AW-1:0]     wptr_reg;
  reg [LOG_AW-1:0]     log_cnt_reg;

  wire [SW-1:0]        thr_ext  = {{(SW-`IFT_THR_W){1'b0}}, spk_thr_reg};
  wire                 start_ok = pickup & ~block_in;
  wire fwd_exp = tick & fwd_run_reg & ~fwd_spike & (fwd_tmr_reg <= T_ONE);
  wire rev_exp = tick & rev_run_reg & ~rev_spike & (rev_tmr_reg <= T_ONE);
  wire                 op_done  = op_run_reg & (op_cnt_reg >= op_delay_reg);
  wire                 spk_ok   = fcnt_reg > thr_ext;
  wire                 intermittent_fault_stage      = fwd_st_reg & (fcnt_reg > S_ONE);
  wire [TW-1:0] remain = op_done ? {TW{1'b0}} :
                         (op_run_reg ? op_delay_reg - op_cnt_reg : op_delay_reg);
  wire [SW-1:0] spk_left = (thr_ext > fcnt_reg) ? thr_ext - fcnt_reg : {SW{1'b0}};
  wire [4:0]    st       = {intermittent_fault_stage, blk_reg, trip_reg, rev_st_reg, fwd_st_reg};
  wire [4:0]    rise     = st & ~st_d_reg;
  wire [4:0]    fall     = ~st & st_d_reg;
  wire [11:0]   new_ev;
  wire [11:0]   grant    = pend_reg & (~pend_reg + 12'h001);
  wire          log_we   = |(grant & `IFT_EV_LOG_MASK);
  wire [4:0]    irq_ev   = {log_we, rise[3:0]};
  wire          wr_int   = bus_wr & (bus_addr == `IFT_REG_INT_STAT);
  wire [4:0]    int_clr  = wr_int ? bus_wdata[4:0] : 5'h00;
  wire [`IFT_REC_W-1:0] rec_q;
  wire          rec_ok   = rec_sel_reg < log_cnt_reg;

  function [3:0] enc12;
    input [11:0] v;
    integer i;
    begin
      enc12 = 4'h0;
      for (i = 11; i >= 0; i = i - 1) begin
        if (v[i]) begin
          enc12 = i[3:0];
        end
      end
    end
  endfunction

  wire [3:0] grant_code = enc12(grant);

  assign forward_start = fwd_st_reg;
  assign reverse_start = rev_st_reg;
  assign trip          = trip_reg;
  assign blocked       = blk_reg;

  // hold timers, in ticks; expiry fires once at the last tick
  always @(posedge mclk) begin
    if (rst) begin
      fwd_tmr_reg <= {TW{1'b0}};
      rev_tmr_reg <= {TW{1'b0}};
      fwd_run_reg <= 1'b0;
      rev_run_reg <= 1'b0;
    end else if (tick) begin
      if (fwd_spike) begin
        fwd_tmr_reg <= fwd_hold_reg;
        fwd_run_reg <= 1'b1;
      end else if (fwd_exp) begin
        fwd_run_reg <= 1'b0;
      end else if (fwd_run_reg) begin
        fwd_tmr_reg <= fwd_tmr_reg - T_ONE;
      end
      if (rev_spike) begin
        rev_tmr_reg <= rev_hold_reg;
        rev_run_reg <= 1'b1;
      end else if (rev_exp) begin
        rev_run_reg <= 1'b0;
      end else if (rev_run_reg) begin
        rev_tmr_reg <= rev_tmr_reg - T_ONE;
      end
    end
  end

  // starts, blocking, operating delay, trip decision
  always @(posedge mclk) begin
    if (rst) begin
      fwd_st_reg <= 1'b0;
      rev_st_reg <= 1'b0;
      blk_reg    <= 1'b0;
      trip_reg   <= 1'b0;
      lock_reg   <= 1'b0;
      op_run_reg <= 1'b0;
      op_cnt_reg <= {TW{1'b0}};
      fcnt_reg   <= {SW{1'b0}};
      rcnt_reg   <= {SW{1'b0}};
      norm_reg   <= 1'b0;
    end else begin
      norm_reg <= tick & normal_fault;
      if (tick) begin
        blk_reg <= pickup & block_in;
        if (block_in | fwd_exp) begin
          fwd_st_reg <= 1'b0;
        end else if (fwd_spike & start_ok) begin
          fwd_st_reg <= 1'b1;
        end
        if (block_in | rev_exp) begin
          rev_st_reg <= 1'b0;
        end else if (rev_spike & start_ok) begin
          rev_st_reg <= 1'b1;
        end
        // a block that lands late still cancels the pending trip here
        if (fwd_exp | block_in) begin
          op_run_reg <= 1'b0;
          op_cnt_reg <= {TW{1'b0}};
        end else if (~op_run_reg & fwd_run_reg & fwd_st_reg) begin
          op_run_reg <= 1'b1;
          op_cnt_reg <= {TW{1'b0}};
        end else if (op_run_reg & (op_cnt_reg < op_delay_reg)) begin
          op_cnt_reg <= op_cnt_reg + T_ONE;
        end
        if (fwd_exp | ~start_ok) begin
          trip_reg <= 1'b0;
        end else if (op_done & spk_ok) begin
          trip_reg <= 1'b1;
        end
        if (fwd_exp) begin
          lock_reg <= 1'b0;
        end else if (op_done & ~spk_ok) begin
          lock_reg <= 1'b1;
        end
        if (fwd_exp) begin
          fcnt_reg <= {SW{1'b0}};
        end else if (fwd_spike & (fcnt_reg != S_MAX)) begin
          fcnt_reg <= fcnt_reg + S_ONE;
        end
        if (rev_exp) begin
          rcnt_reg <= {SW{1'b0}};
        end else if (rev_spike & (rcnt_reg != S_MAX)) begin
          rcnt_reg <= rcnt_reg + S_ONE;
        end
      end
    end
  end

  // status edges into selectable event codes
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_ev
      assign new_ev[2*g]   = rise[g] & evsel_reg[2*g];
      assign new_ev[2*g+1] = fall[g] & evsel_reg[2*g+1];
    end
  endgenerate
  assign new_ev[`IFT_EV_NORMAL] = norm_reg;
  assign new_ev[`IFT_EV_LOCKED] = lock_reg & ~lock_d_reg;

  // one event out per cycle; pending set wins over its own grant
  always @(posedge mclk) begin
    if (rst) begin
      st_d_reg      <= 5'h00;
      lock_d_reg    <= 1'b0;
      pend_reg      <= 12'h000;
      evt_valid     <= 1'b0;
      evt_code      <= 4'h0;
      evt_time      <= 48'h000000000000;
      evt_remain    <= {TW{1'b0}};
      evt_fwd_count <= {SW{1'b0}};
      evt_rev_count <= {SW{1'b0}};
      snap_time_reg <= 48'h000000000000;
      snap_rem_reg  <= {TW{1'b0}};
      snap_f_reg    <= {SW{1'b0}};
      snap_r_reg    <= {SW{1'b0}};
      snap_left_reg <= {SW{1'b0}};
      snap_fst_reg  <= 1'b0;
      snap_rst_reg  <= 1'b0;
    end else begin
      st_d_reg   <= st;
      lock_d_reg <= lock_reg;
      pend_reg   <= (pend_reg & ~grant) | new_ev;
      // snapshot shared by events of one tick; ticks are far apart
      if (|new_ev) begin
        snap_time_reg <= time_ms;
        snap_rem_reg  <= remain;
        snap_f_reg    <= fcnt_reg;
        snap_r_reg    <= rcnt_reg;
        snap_left_reg <= spk_left;
        snap_fst_reg  <= fwd_st_reg;
        snap_rst_reg  <= rev_st_reg;
      end
      evt_valid     <= |pend_reg;
      evt_code      <= grant_code;
      evt_time      <= snap_time_reg;
      evt_remain    <= snap_rem_reg;
      evt_fwd_count <= snap_f_reg;
      evt_rev_count <= snap_r_reg;
    end
  end

  // circular record log
  always @(posedge mclk) begin
    if (rst) begin
      wptr_reg    <= {LOG_AW{1'b0}};
      log_cnt_reg <= {LOG_AW{1'b0}};
    end else if (log_we) begin
      wptr_reg <= (wptr_reg == A_LAST) ? {LOG_AW{1'b0}} : wptr_reg + A_ONE;
      if (log_cnt_reg != A_FULL) begin
        log_cnt_reg <= log_cnt_reg + A_ONE;
      end
    end
  end

  ift_log_mem #(
    .W     (`IFT_REC_W),
    .DEPTH (LOG_DEPTH),
    .AW    (LOG_AW)
  ) u_log (
    .mclk  (mclk),
    .we    (log_we),
    .waddr (wptr_reg),
    .wdata ({{(32-SW){1'b0}}, snap_left_reg, snap_f_reg, snap_r_reg,
             {(32-TW){1'b0}}, snap_rem_reg, grant_code, grp_reg,
             snap_fst_reg, snap_rst_reg, 7'h00, snap_time_reg}),
    .raddr (rec_sel_reg),
    .rdata (rec_q)
  );

  // register writes and interrupt status
  always @(posedge mclk) begin
    if (rst) begin
      fwd_hold_reg <= FWD_RST;
      rev_hold_reg <= REV_RST;
      op_delay_reg <= OP_RST;
      spk_thr_reg  <= `IFT_SPK_THR_RST;
      grp_reg      <= `IFT_GRP_RST;
      evsel_reg    <= `IFT_EVSEL_RST;
      int_mask_reg <= 5'h00;
      int_stat_reg <= 5'h00;
      rec_sel_reg  <= {LOG_AW{1'b0}};
      irq          <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | irq_ev;
      irq          <= |(int_stat_reg & int_mask_reg);
      if (bus_wr) begin
        case (bus_addr)
          `IFT_REG_CFG: begin
            grp_reg   <= bus_wdata[`IFT_CFG_GRP_LSB +: 3];
            evsel_reg <= bus_wdata[`IFT_CFG_EVSEL_LSB +: 10];
          end
          `IFT_REG_FWD_HOLD: fwd_hold_reg <= bus_wdata[TW-1:0];
          `IFT_REG_REV_HOLD: rev_hold_reg <= bus_wdata[TW-1:0];
          `IFT_REG_OP_DELAY: op_delay_reg <= bus_wdata[TW-1:0];
          `IFT_REG_SPK_THR:  spk_thr_reg  <= bus_wdata[`IFT_THR_W-1:0];
          `IFT_REG_INT_MASK: int_mask_reg <= bus_wdata[4:0];
          `IFT_REG_REC_SEL:  rec_sel_reg  <= bus_wdata[LOG_AW-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_rd) begin
      case (bus_addr)
        `IFT_REG_CFG:      bus_rdata <= {18'h00000, evsel_reg, 1'b0, grp_reg};
        `IFT_REG_FWD_HOLD: bus_rdata <= {{(32-TW){1'b0}}, fwd_hold_reg};
        `IFT_REG_REV_HOLD: bus_rdata <= {{(32-TW){1'b0}}, rev_hold_reg};
        `IFT_REG_OP_DELAY: bus_rdata <= {{(32-TW){1'b0}}, op_delay_reg};
        `IFT_REG_SPK_THR:  bus_rdata <= {{(32-`IFT_THR_W){1'b0}}, spk_thr_reg};
        `IFT_REG_STATUS:   bus_rdata <= {{(24-LOG_AW){1'b0}}, log_cnt_reg,
                                         2'h0, lock_reg, st};
        `IFT_REG_INT_STAT: bus_rdata <= {27'h0000000, int_stat_reg};
        `IFT_REG_INT_MASK: bus_rdata <= {27'h0000000, int_mask_reg};
        `IFT_REG_REC_SEL:  bus_rdata <= {{(32-LOG_AW){1'b0}}, rec_sel_reg};
        `IFT_REG_REC_W0:   bus_rdata <= rec_ok ? rec_q[31:0]    : 32'h00000000;
        `IFT_REG_REC_W1:   bus_rdata <= rec_ok ? rec_q[63:32]   : 32'h00000000;
        `IFT_REG_REC_W2:   bus_rdata <= rec_ok ? rec_q[95:64]   : 32'h00000000;
        `IFT_REG_REC_W3:   bus_rdata <= rec_ok ? rec_q[127:96]  : 32'h00000000;
        `IFT_REG_REC_W4:   bus_rdata <= rec_ok ? rec_q[159:128] : 32'h00000000;
        `IFT_REG_COUNTS:   bus_rdata <= {fcnt_reg, rcnt_reg};
        `IFT_REG_REMAIN:   bus_rdata <= {{(32-TW){1'b0}}, remain};
        default:           bus_rdata <= 32'h00000000;
      endcase
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end
endmodule // ift_trip_timer
`default_nettype wire

// ---- verification/ift_assertions.sv ----
// port checker for the intermittent fault trip timer
`timescale 1ns/100ps
`default_nettype none
module ift_assertions (
  input wire        mclk,
  input wire        rst,
  input wire        tick,
  input wire        fwd_spike,
  input wire        rev_spike,
  input wire        pickup,
  input wire        block_in,
  input wire        bus_rd,
  input wire [31:0] bus_rdata,
  input wire        forward_start,
  input wire        reverse_start,
  input wire        trip,
  input wire        blocked,
  input wire        evt_valid,
  input wire [3:0]  evt_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire fwd_arm  = tick & fwd_spike & pickup & ~block_in;
  wire rev_arm  = tick & rev_spike & pickup & ~block_in;
  wire trip_arm = tick & pickup & ~block_in;
  wire blk_arm  = tick & pickup & block_in;
  property p_fwd_rise;
    $rose(forward_start) |-> $past(fwd_arm);
  endproperty
  a_fwd_rise: assert property (p_fwd_rise) else $error("fwd start no spike");
  property p_rev_rise;
    $rose(reverse_start) |-> $past(rev_arm);
  endproperty
  a_rev_rise: assert property (p_rev_rise) else $error("rev start no spike");
  property p_trip_rise;
    $rose(trip) |-> $past(trip_arm);
  endproperty
  a_trip_rise: assert property (p_trip_rise) else $error("trip bad cause");
  property p_trip_fwd;
    trip |-> forward_start;
  endproperty
  a_trip_fwd: assert property (p_trip_fwd) else $error("trip w/o fwd start");
  property p_blk_rise;
    $rose(blocked) |-> $past(blk_arm);
  endproperty
  a_blk_rise: assert property (p_blk_rise) else $error("blocked bad cause");
  property p_blk_excl;
    blocked |-> !forward_start && !reverse_start;
  endproperty
  a_blk_excl: assert property (p_blk_excl) else $error("start while blocked");
  // a second reset in mid-run also moves outputs, hence the past reset guard
  property p_tick_only;
    !$past(rst) && ($changed(trip) || $changed(blocked) || $changed(forward_start)
      || $changed(reverse_start)) |-> $past(tick);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("output moved off tick");
  property p_evt_code;
    evt_valid |-> evt_code <= 4'hB;
  endproperty
  a_evt_code: assert property (p_evt_code) else $error("event code range");
  property p_rdata;
    bus_rdata != 32'h0 |-> $past(bus_rd);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data off slot");
  c_trip: cover property ($rose(trip));
  c_blk: cover property ($rose(blocked));
  c_lock: cover property (evt_valid && evt_code == 4'hB);
endmodule // ift_assertions
bind ift_trip_timer ift_assertions u_ift_assertions (
  .mclk(mclk), .rst(rst), .tick(tick), .fwd_spike(fwd_spike), .rev_spike(rev_spike),
  .pickup(pickup), .block_in(block_in), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .forward_start(forward_start), .reverse_start(reverse_start), .trip(trip),
  .blocked(blocked), .evt_valid(evt_valid), .evt_code(evt_code)
);
`default_nettype wire

// ---- verification/ift_partner.sv ----
// spike detector, pick-up element and blocking matrix model
`timescale 1ns/100ps
`default_nettype none
module ift_partner (
  input  wire         mclk,
  input  wire         rst,
  input  wire         fwd_req,
  input  wire         rev_req,
  input  wire         pick_req,
  input  wire         blk_req,
  input  wire         nf_req,
  output logic        tick,
  output wire         fwd_spike,
  output wire         rev_spike,
  output logic        pickup,
  output logic        block_in,
  output logic        normal_fault,
  output logic [47:0] time_ms
);
  logic [3:0] cnt_reg;
  always @(posedge mclk) begin
    cnt_reg <= rst ? 4'h0 : cnt_reg + 4'h1;
    tick <= !rst && (cnt_reg == 4'hF);
    pickup <= pick_req;
    normal_fault <= nf_req;
    block_in <= blk_req;
    // stamp moves mid-period so a tick never straddles it
    if (rst)
      time_ms <= 48'h0;
    else if (cnt_reg == 4'h7)
      time_ms <= time_ms + 48'h5;
  end
  // outside ticks the spike lines wobble, nothing may rely on them
  assign fwd_spike = tick ? fwd_req : cnt_reg[0];
  assign rev_spike = tick ? rev_req : !cnt_reg[0];
endmodule // ift_partner
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the trip timer
`include "ift_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk, rst, fwd_req, rev_req, pick_req, blk_req, nf_req, tick;
  logic        fwd_spike, rev_spike, pickup, block_in, normal_fault, bus_wr, bus_rd;
  logic        forward_start, reverse_start, trip, blocked, evt_valid, irq, ev_clr;
  logic [47:0] time_ms, evt_time, t_tick, t_fwd, t0;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata, rd_data, tr_cnt;
  logic [3:0]  evt_code;
  logic [18:0] evt_remain, f_rem;
  logic [15:0] evt_fwd_count, evt_rev_count;
  logic [11:0] ev_seen;
  int          failures, samples_checked, i;
  localparam logic [7:0]  RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'hFC};
  localparam logic [31:0] RV [6] = '{32'h3FF0, 32'h3C, 32'h3C, 32'h64, 32'h2, 32'h0};
  ift_trip_timer u_ift_trip_timer (
    .mclk(mclk), .rst(rst), .tick(tick), .fwd_spike(fwd_spike), .rev_spike(rev_spike),
    .pickup(pickup), .block_in(block_in), .normal_fault(normal_fault), .time_ms(time_ms),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .forward_start(forward_start), .reverse_start(reverse_start),
    .trip(trip), .blocked(blocked), .evt_valid(evt_valid), .evt_code(evt_code),
    .evt_time(evt_time), .evt_remain(evt_remain), .evt_fwd_count(evt_fwd_count),
    .evt_rev_count(evt_rev_count), .irq(irq)
  );
  ift_partner u_ift_partner (
    .mclk(mclk), .rst(rst), .fwd_req(fwd_req), .rev_req(rev_req), .pick_req(pick_req),
    .blk_req(blk_req), .nf_req(nf_req), .tick(tick), .fwd_spike(fwd_spike),
    .rev_spike(rev_spike), .pickup(pickup), .block_in(block_in),
    .normal_fault(normal_fault), .time_ms(time_ms)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // one writer for the seen flags; the bench clears them by request
  always @(posedge mclk) begin
    if (rst || ev_clr)
      ev_seen <= '0;
    else if (evt_valid === 1'b1)
      ev_seen[evt_code] <= 1'b1;
    if (evt_valid === 1'b1 && evt_code === `IFT_EV_FWD_ON) begin
      t_fwd <= evt_time;
      f_rem <= evt_remain;
    end
    if (evt_valid === 1'b1 && evt_code === `IFT_EV_TRIP_ON)
      tr_cnt <= {evt_fwd_count, evt_rev_count};
  end
  task automatic end_of_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    // idle edge so a following write never re-drives the strobe in this step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(posedge mclk);
    rd_data = bus_rdata;
  endtask
  task automatic lv(input logic p, input logic b);
    pick_req <= p;
    blk_req <= b;
    nf_req <= b;
    repeat (2) @(posedge mclk);
  endtask
  // one processing tick, spikes offered only for that tick
  task automatic step(input logic f, input logic r);
    int n;
    n = 0;
    fwd_req <= f;
    rev_req <= r;
    @(posedge mclk);
    while (tick !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n == 40) begin
      failures++;
      end_of_test;
    end
    t_tick = time_ms;
    fwd_req <= 1'b0;
    rev_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_reset;
    for (i = 0; i < 6; i++) begin
      rd(RA[i]);
      chk(rd_data, RV[i]);
    end
    chk({forward_start, reverse_start, trip, blocked, irq}, 5'h0);
    wr(`IFT_REG_FWD_HOLD, 32'h3);
    wr(`IFT_REG_REV_HOLD, 32'h4);
    wr(`IFT_REG_OP_DELAY, 32'h5);
  endtask
  task automatic t_fwd_hold;
    lv(1'b1, 1'b0);
    step(1'b1, 1'b0);
    t0 = t_tick;
    chk(forward_start, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    rd(`IFT_REG_COUNTS);
    chk(rd_data, 32'h00020000);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    chk(forward_start, 1'b1);
    chk(t_fwd[31:0], t0[31:0]);
    chk(f_rem, 32'h5);
    step(1'b0, 1'b0);
    chk(forward_start, 1'b0);
    repeat (3) @(posedge mclk);
    chk(ev_seen[1:0], 2'h3);
  endtask
  task automatic t_rev_hold;
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    chk({forward_start, reverse_start}, 2'h1);
    rd(`IFT_REG_COUNTS);
    chk(rd_data, 32'h00000002);
    repeat (3) step(1'b0, 1'b0);
    chk(reverse_start, 1'b1);
    step(1'b0, 1'b0);
    chk(reverse_start, 1'b0);
  endtask
  task automatic t_trip;
    for (i = 0; i < 5; i++)
      step(1'b1, 1'b0);
    chk(trip, 1'b0);
    for (i = 0; i < 6 && trip !== 1'b1; i++)
      step(1'b1, 1'b0);
    chk(trip, 1'b1);
    rd(`IFT_REG_STATUS);
    chk(rd_data[11:8], 4'h4);
    chk(tr_cnt, 32'h00080000);
    wr(`IFT_REG_REC_SEL, 32'h3);
    repeat (2) @(posedge mclk);
    rd(`IFT_REG_REC_W1);
    chk(rd_data[31:24], 8'h41);
    rd(`IFT_REG_REC_W4);
    chk(rd_data, 32'h0);
    lv(1'b0, 1'b0);
    step(1'b0, 1'b0);
    chk(trip, 1'b0);
    repeat (3) step(1'b0, 1'b0);
    chk(forward_start, 1'b0);
    rd(`IFT_REG_REMAIN);
    chk(rd_data, 32'h5);
  endtask
  task automatic t_lock;
    wr(`IFT_REG_SPK_THR, 32'h32);
    lv(1'b1, 1'b0);
    for (i = 0; i < 9; i++)
      step(1'b1, 1'b0);
    chk(trip, 1'b0);
    rd(`IFT_REG_STATUS);
    chk(rd_data[5], 1'b1);
    repeat (3) step(1'b0, 1'b0);
    chk(forward_start, 1'b0);
    chk(ev_seen[11], 1'b1);
    wr(`IFT_REG_SPK_THR, 32'h2);
  endtask
  task automatic t_block;
    step(1'b1, 1'b0);
    lv(1'b1, 1'b1);
    step(1'b0, 1'b0);
    chk({blocked, forward_start}, 2'h2);
    lv(1'b1, 1'b0);
    step(1'b0, 1'b0);
    chk(blocked, 1'b0);
    repeat (3) @(posedge mclk);
    chk({ev_seen[10], ev_seen[7:6]}, 3'h7);
  endtask
  task automatic t_sel_irq;
    ev_clr <= 1'b1;
    @(posedge mclk);
    ev_clr <= 1'b0;
    wr(`IFT_REG_CFG, 32'h13);
    wr(`IFT_REG_INT_STAT, 32'h1F);
    step(1'b1, 1'b0);
    repeat (3) step(1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    chk(ev_seen[1:0], 2'h1);
    chk(irq, 1'b0);
    rd(`IFT_REG_INT_STAT);
    chk(rd_data[0], 1'b1);
    wr(`IFT_REG_INT_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wr(`IFT_REG_INT_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    wr(`IFT_REG_REC_SEL, 32'h7);
    repeat (2) @(posedge mclk);
    rd(`IFT_REG_REC_W1);
    chk(rd_data[31:24], 8'h07);
    wr(`IFT_REG_CFG, 32'h3FF0);
  endtask
  initial begin
    rst = 1'b1;
    {fwd_req, rev_req, pick_req, blk_req, nf_req, bus_wr, bus_rd} = 7'h0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    ev_clr = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_fwd_hold;
    t_rev_hold;
    t_trip;
    t_lock;
    t_block;
    t_sel_irq;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
